// *** hdl/ocad_char_attr.sv ***
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "ocad_defs.svh"

// What this block does
// - Caption and standard modes: font code is nine low bits plus one high bit.
// - Caption mode: three first-attribute bits give foreground palette bits 0 to 2.
// - Standard mode: four first-attribute bits give foreground palette bits 0 to 3.
// - Caption mode: italic bit set renders italic, clear renders upright.
// - Caption mode: flash bit set flashes the character, clear shows it steady.
// - Caption mode: underline bit set draws an underline, clear omits it.
// - All modes: secondary blank output follows each character's secondary bit.
// - Caption and standard modes: background palette comes from the attribute bytes.
// - Colour-dot mode: font dots picking palette 0 take the per-character dot colour.
// - Bits 3 to 7 of the second attribute byte read back as zero.
// - Attribute bits unused in a mode keep their written value and read back, except bits 3 to 7 of the second byte.
// - Each character has separately addressed code, first and second attribute bytes.
// - Palette 0 is transparent and palette 8 is black, always.
// - Caption mode: a control bit picks foreground palettes 0 to 7 or 8 to 15.
module ocad_char_attr (
    // Clock, reset and enable
    input  wire logic                       clk_i,                     // System clock, 100 MHz
    input  wire logic                       arst_n_i,                  // Async reset, active low
    input  wire logic                       ce_i,                      // Clock enable, freezes all state

    // Avalon-MM register slave
    input  wire logic [`OCAD_ADDR_W-1:0]    avs_address_i,             // Avalon byte address
    input  wire logic                       avs_read_i,                // Avalon read
    input  wire logic                       avs_write_i,               // Avalon write
    input  wire logic [3:0]                 avs_byteenable_i,          // Avalon byte enables
    input  wire logic [31:0]                avs_writedata_i,           // Avalon write data
    output logic      [31:0]                avs_readdata_o,            // Avalon read data
    output logic                            avs_waitrequest_o,         // Avalon wait request

    // Display fetch, one character per strobe
    input  wire logic                       disp_req_i,                // Display fetch request
    input  wire logic [`OCAD_IDX_W-1:0]     disp_index_i,              // Character to fetch
    input  wire logic [3:0]                 font_dot_pal_i,            // Palette chosen by font dot

    // Decoded fields, held from one fetch to the next
    output logic                            disp_valid_o,              // Decoded fields valid
    output logic      [9:0]                 char_code_o,               // Font ROM code
    output logic      [3:0]                 fg_pal_o,                  // Foreground palette
    output logic      [3:0]                 bg_pal_o,                  // Background palette
    output logic                            italic_o,                  // Italic rendering
    output logic                            flash_o,                   // Flash rendering
    output logic                            underline_o,               // Underline rendering
    output logic                            secondary_blank_output_o,  // Secondary blanking
    output logic                            fg_transparent_o,          // Foreground transparent
    output logic                            fg_black_o,                // Foreground black
    output logic                            bg_transparent_o,          // Background transparent
    output logic                            bg_black_o                 // Background black
);

    // Bus sequencer state
    ocad_pkg::ocad_bus_state_e   state_ff;
    ocad_pkg::ocad_bus_state_e   nxt_state;
    logic                        wait_ff;
    logic                        nxt_wait;
    // Read answer, held until the next access answers
    logic [31:0]                 rdata_ff;
    logic [31:0]                 nxt_rdata;

    // Control register
    logic [`OCAD_CTRL_W-1:0]     ctrl_ff;
    logic [`OCAD_CTRL_W-1:0]     nxt_ctrl;
    // Decoded mode; reserved code shows as standard
    ocad_pkg::ocad_mode_e        mode;

    // Display pipeline
    logic                        req_d_ff;
    logic [3:0]                  font_d_ff;
    logic                        valid_ff;

    // Decoded field registers
    logic [9:0]                  code_ff;
    logic [3:0]                  fg_ff;
    logic [3:0]                  bg_ff;
    logic                        italic_ff;
    logic                        flash_ff;
    logic                        underline_ff;
    logic                        sec_ff;
    logic                        fg_tr_ff;
    logic                        fg_bk_ff;
    logic                        bg_tr_ff;
    logic                        bg_bk_ff;

    // Wires between submodules
    logic [1:0]                  region;
    logic [`OCAD_IDX_W-1:0]      index;
    logic                        ram_wr;
    logic [7:0]                  ram_rdata;

    // Raw bytes of the fetched character
    logic [7:0]                  d_code;
    logic [7:0]                  d_attr1;
    logic [`OCAD_ATTR2_W-1:0]    d_attr2;

    // Decoder results, captured by stage two
    logic [9:0]                  dc_code;
    logic [3:0]                  dc_fg;
    logic [3:0]                  dc_bg;
    logic                        dc_italic;
    logic                        dc_flash;
    logic                        dc_underline;
    logic                        dc_sec;
    logic                        dc_fg_tr;
    logic                        dc_fg_bk;
    logic                        dc_bg_tr;
    logic                        dc_bg_bk;

    // Write strobe qualified by the handshake
    logic                        commit;

    // Address split: region picks the byte array, the word index picks the character
    // Bits [1:0] are ignored except at the control offsets, which match the full address: one byte per word
    assign region = avs_address_i[11:10];
    assign index  = avs_address_i[9:2];

    // A write lands only at the edge where the master sees waitrequest low
    assign commit = (state_ff == ocad_pkg::OCAD_BUS_DONE) && avs_write_i;
    assign ram_wr = commit && avs_byteenable_i[0] && (region != `OCAD_REGION_CTRL);

    // Illegal mode code falls back to standard overlay
    // so a stray write never blanks the display
    always_comb begin
        unique case (ctrl_ff[`OCAD_CTRL_MODE_MSB:`OCAD_CTRL_MODE_LSB])
            `OCAD_MODE_CAPTION: mode = ocad_pkg::OCAD_CAPTION;
            `OCAD_MODE_DOT:     mode = ocad_pkg::OCAD_COLOUR_DOT;
            default:            mode = ocad_pkg::OCAD_STANDARD;
        endcase
    end

    // Store: bus port and display port share only the arrays
    ocad_char_ram u_ram (
        .clk_i        (clk_i),
        .arst_n_i     (arst_n_i),
        .ce_i         (ce_i),
        .wr_en_i      (ram_wr),
        .wr_region_i  (region),
        .wr_index_i   (index),
        .wr_data_i    (avs_writedata_i[7:0]),
        .rd_region_i  (region),
        .rd_index_i   (index),
        .rd_data_o    (ram_rdata),
        .disp_en_i    (disp_req_i),
        .disp_index_i (disp_index_i),
        .disp_code_o  (d_code),
        .disp_attr1_o (d_attr1),
        .disp_attr2_o (d_attr2)
    );

    // Decode is pure logic; stage two registers it
    ocad_decode u_decode (
        .mode_i           (mode),
        .bank_i           (ctrl_ff[`OCAD_CTRL_BANK]),
        .code_i           (d_code),
        .attr1_i          (d_attr1),
        .attr2_i          (d_attr2),
        .font_pal_i       (font_d_ff),
        .char_code_o      (dc_code),
        .fg_pal_o         (dc_fg),
        .bg_pal_o         (dc_bg),
        .italic_o         (dc_italic),
        .flash_o          (dc_flash),
        .underline_o      (dc_underline),
        .sec_blank_o      (dc_sec),
        .fg_transparent_o (dc_fg_tr),
        .fg_black_o       (dc_fg_bk),
        .bg_transparent_o (dc_bg_tr),
        .bg_black_o       (dc_bg_bk)
    );

    // Bus sequencer: one cycle to latch the address, one to fetch, then answer.
    // Costs two wait cycles per access but keeps every bus output on a flop.
    // Back-to-back accesses cost three edges each.
    always_comb begin
        nxt_state = state_ff;
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        nxt_ctrl  = ctrl_ff;
        unique case (state_ff)
            ocad_pkg::OCAD_BUS_IDLE: begin
                // RAM read port latches the address at this edge
                if (avs_read_i || avs_write_i) begin
                    nxt_state = ocad_pkg::OCAD_BUS_FETCH;
                end
            end

            ocad_pkg::OCAD_BUS_FETCH: begin
                // RAM byte is ready; answer at the next edge
                nxt_state = ocad_pkg::OCAD_BUS_DONE;
                nxt_wait  = 1'b0;
                // Unmapped control offsets read as zero
                nxt_rdata = 32'h0000_0000;
                if (region != `OCAD_REGION_CTRL) begin
                    nxt_rdata = {24'h00_0000, ram_rdata};
                end else if (avs_address_i == `OCAD_CTRL_OFS) begin
                    nxt_rdata = {29'h0000_0000, ctrl_ff};
                end else if (avs_address_i == `OCAD_STAT_OFS) begin
                    // Last decoded character, so software can see what the display used
                    nxt_rdata = {13'h0000, valid_ff, bg_ff, fg_ff, code_ff};
                end
            end

            ocad_pkg::OCAD_BUS_DONE: begin
                // Master sees waitrequest low; a write lands here
                nxt_state = ocad_pkg::OCAD_BUS_IDLE;
                // Status and unmapped control writes are dropped
                if (commit && avs_byteenable_i[0] && (avs_address_i == `OCAD_CTRL_OFS)) begin
                    nxt_ctrl = avs_writedata_i[`OCAD_CTRL_W-1:0];
                end
            end

            default: begin
                // Unused state code: back to idle
                nxt_state = ocad_pkg::OCAD_BUS_IDLE;
            end
        endcase
    end

    // Bus and control registers
    // ce_i low holds them, even mid-access
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ocad_pkg::OCAD_BUS_IDLE;
            // High at idle: a request always waits
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff  <= `OCAD_CTRL_RESET;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
            ctrl_ff  <= nxt_ctrl;
        end
    end

    // Display pipeline: stage one reads the bytes, stage two registers the decode.
    // Control changes take effect at the stage-two edge, so a character already mid-fetch decodes with them.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            req_d_ff     <= 1'b0;
            font_d_ff    <= 4'h0;
            valid_ff     <= 1'b0;
            code_ff      <= 10'h000;
            fg_ff        <= 4'h0;
            bg_ff        <= 4'h0;
            italic_ff    <= 1'b0;
            flash_ff     <= 1'b0;
            underline_ff <= 1'b0;
            sec_ff       <= 1'b0;
            // Palette 0 after reset, so both clear flags start set
            fg_tr_ff     <= 1'b1;
            fg_bk_ff     <= 1'b0;
            bg_tr_ff     <= 1'b1;
            bg_bk_ff     <= 1'b0;
        end else if (ce_i) begin
            // Stage one: strobe and font palette ride with the RAM read
            req_d_ff <= disp_req_i;
            valid_ff <= req_d_ff;

            if (disp_req_i) begin
                font_d_ff <= font_dot_pal_i;
            end
            // Stage two: capture only on a fetch, so fields hold
            if (req_d_ff) begin
                code_ff      <= dc_code;
                fg_ff        <= dc_fg;
                bg_ff        <= dc_bg;
                italic_ff    <= dc_italic;
                flash_ff     <= dc_flash;
                underline_ff <= dc_underline;
                sec_ff       <= dc_sec;
                fg_tr_ff     <= dc_fg_tr;
                fg_bk_ff     <= dc_fg_bk;
                bg_tr_ff     <= dc_bg_tr;
                bg_bk_ff     <= dc_bg_bk;
            end
        end
    end

    // Every output straight from a flop
    // Bus side
    assign avs_readdata_o           = rdata_ff;
    assign avs_waitrequest_o        = wait_ff;

    // Display side
    assign disp_valid_o             = valid_ff;
    assign char_code_o              = code_ff;
    assign fg_pal_o                 = fg_ff;
    assign bg_pal_o                 = bg_ff;
    assign italic_o                 = italic_ff;
    assign flash_o                  = flash_ff;
    assign underline_o              = underline_ff;
    assign secondary_blank_output_o = sec_ff;

    // Fixed palette flags
    assign fg_transparent_o         = fg_tr_ff;
    assign fg_black_o               = fg_bk_ff;
    assign bg_transparent_o         = bg_tr_ff;
    assign bg_black_o               = bg_bk_ff;

endmodule

// *** hdl/ocad_defs.svh ***
`ifndef OCAD_DEFS_SVH
`define OCAD_DEFS_SVH

// Character store geometry
`define OCAD_IDX_W          8
`define OCAD_CHARS          256
`define OCAD_ATTR2_W        3

// Byte address map, address[11:10] picks the region, address[9:2] the character
`define OCAD_ADDR_W         12
`define OCAD_REGION_CODE    2'h0
`define OCAD_REGION_ATTR1   2'h1
`define OCAD_REGION_ATTR2   2'h2
`define OCAD_REGION_CTRL    2'h3
`define OCAD_CTRL_OFS       12'hc00
`define OCAD_STAT_OFS       12'hc04

// First attribute byte fields
`define OCAD_A1_CODE_BIT8   0
`define OCAD_A1_FG0         1
`define OCAD_A1_FG1         2
`define OCAD_A1_FG2         3
`define OCAD_A1_B4          4
`define OCAD_A1_B5          5
`define OCAD_A1_B6          6
`define OCAD_A1_SEC         7

// Second attribute byte fields
`define OCAD_A2_BG0         0
`define OCAD_A2_BG1         1
`define OCAD_A2_CODE_HIGH   2

// Control register fields and reset value
`define OCAD_CTRL_MODE_LSB  0
`define OCAD_CTRL_MODE_MSB  1
`define OCAD_CTRL_BANK      2
`define OCAD_CTRL_W         3
`define OCAD_CTRL_RESET     3'h0
`define OCAD_MODE_CAPTION   2'h0
`define OCAD_MODE_STANDARD  2'h1
`define OCAD_MODE_DOT       2'h2

// Fixed palettes
`define OCAD_PAL_TRANSPARENT 4'h0
`define OCAD_PAL_BLACK       4'h8

`endif

// *** hdl/ocad_pkg.sv ***
package ocad_pkg;

    // Display modes
    typedef enum logic [1:0] {
        OCAD_CAPTION,
        OCAD_STANDARD,
        OCAD_COLOUR_DOT
    } ocad_mode_e;

    // Bus access sequencer states
    typedef enum logic [1:0] {
        OCAD_BUS_IDLE,
        OCAD_BUS_FETCH,
        OCAD_BUS_DONE
    } ocad_bus_state_e;

endpackage

// *** hdl/ocad_char_ram.sv ***
`timescale 1ns/1ns
`include "ocad_defs.svh"

module ocad_char_ram (
    input  wire logic                        clk_i,        // System clock
    input  wire logic                        arst_n_i,     // Async reset, active low
    input  wire logic                        ce_i,         // Clock enable
    input  wire logic                        wr_en_i,      // Write strobe
    input  wire logic [1:0]                  wr_region_i,  // Byte array to write
    input  wire logic [`OCAD_IDX_W-1:0]      wr_index_i,   // Character index for write
    input  wire logic [7:0]                  wr_data_i,    // Write byte
    input  wire logic [1:0]                  rd_region_i,  // Byte array to read
    input  wire logic [`OCAD_IDX_W-1:0]      rd_index_i,   // Character index for bus read
    output logic      [7:0]                  rd_data_o,    // Bus read byte
    input  wire logic                        disp_en_i,    // Display fetch strobe
    input  wire logic [`OCAD_IDX_W-1:0]      disp_index_i, // Character index for display
    output logic      [7:0]                  disp_code_o,  // Code byte
    output logic      [7:0]                  disp_attr1_o, // First attribute byte
    output logic      [`OCAD_ATTR2_W-1:0]    disp_attr2_o  // Second attribute byte
);

    // Three separate byte arrays per character position
    logic [7:0]               code_mem  [`OCAD_CHARS];
    logic [7:0]               attr1_mem [`OCAD_CHARS];
    logic [`OCAD_ATTR2_W-1:0] attr2_mem [`OCAD_CHARS];

    logic [7:0]               nxt_rd_data;

    // Memories are not reset; software loads them before display
    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            if (wr_region_i == `OCAD_REGION_CODE) begin
                code_mem[wr_index_i] <= wr_data_i;
            end
            if (wr_region_i == `OCAD_REGION_ATTR1) begin
                attr1_mem[wr_index_i] <= wr_data_i;
            end
            if (wr_region_i == `OCAD_REGION_ATTR2) begin
                attr2_mem[wr_index_i] <= wr_data_i[`OCAD_ATTR2_W-1:0];
            end
        end
    end

    // Bus read mux; upper bits of the second attribute byte read as zero
    always_comb begin
        nxt_rd_data = 8'h00;
        unique case (rd_region_i)
            `OCAD_REGION_CODE:  nxt_rd_data = code_mem[rd_index_i];
            `OCAD_REGION_ATTR1: nxt_rd_data = attr1_mem[rd_index_i];
            `OCAD_REGION_ATTR2: nxt_rd_data = {5'h00, attr2_mem[rd_index_i]};
            default:            nxt_rd_data = 8'h00;
        endcase
    end

    // Registered read ports; a same-cycle write returns the old byte
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o    <= 8'h00;
            disp_code_o  <= 8'h00;
            disp_attr1_o <= 8'h00;
            disp_attr2_o <= '0;
        end else if (ce_i) begin
            rd_data_o <= nxt_rd_data;
            if (disp_en_i) begin
                disp_code_o  <= code_mem[disp_index_i];
                disp_attr1_o <= attr1_mem[disp_index_i];
                disp_attr2_o <= attr2_mem[disp_index_i];
            end
        end
    end

endmodule

// *** hdl/ocad_decode.sv ***
`timescale 1ns/1ns
`include "ocad_defs.svh"

module ocad_decode (
    input  wire ocad_pkg::ocad_mode_e          mode_i,           // Display mode
    input  wire logic                          bank_i,           // Caption palette bank
    input  wire logic [7:0]                    code_i,           // Code byte
    input  wire logic [7:0]                    attr1_i,          // First attribute byte
    input  wire logic [`OCAD_ATTR2_W-1:0]      attr2_i,          // Second attribute byte
    input  wire logic [3:0]                    font_pal_i,       // Palette picked by font dot
    output logic      [9:0]                    char_code_o,      // Font ROM code
    output logic      [3:0]                    fg_pal_o,         // Foreground palette
    output logic      [3:0]                    bg_pal_o,         // Background palette
    output logic                               italic_o,         // Italic on
    output logic                               flash_o,          // Flash on
    output logic                               underline_o,      // Underline on
    output logic                               sec_blank_o,      // Secondary blank on
    output logic                               fg_transparent_o, // Foreground is palette 0
    output logic                               fg_black_o,       // Foreground is palette 8
    output logic                               bg_transparent_o, // Background is palette 0
    output logic                               bg_black_o        // Background is palette 8
);

    logic [3:0] dot_pal;

    assign dot_pal = attr1_i[`OCAD_A1_B6:`OCAD_A1_FG2];

    // Field selection per mode; bits unused by a mode do not reach the display
    always_comb begin
        char_code_o = {attr2_i[`OCAD_A2_CODE_HIGH], attr1_i[`OCAD_A1_CODE_BIT8], code_i};
        fg_pal_o    = attr1_i[`OCAD_A1_B4:`OCAD_A1_FG0];
        bg_pal_o    = {attr2_i[`OCAD_A2_BG1:`OCAD_A2_BG0], attr1_i[`OCAD_A1_B6:`OCAD_A1_B5]};
        italic_o    = 1'b0;
        flash_o     = 1'b0;
        underline_o = 1'b0;
        unique case (mode_i)
            ocad_pkg::OCAD_CAPTION: begin
                fg_pal_o    = {bank_i, attr1_i[`OCAD_A1_FG2:`OCAD_A1_FG0]};
                bg_pal_o    = {2'h0, attr2_i[`OCAD_A2_BG1:`OCAD_A2_BG0]};
                italic_o    = attr1_i[`OCAD_A1_B4];
                flash_o     = attr1_i[`OCAD_A1_B5];
                underline_o = attr1_i[`OCAD_A1_B6];
            end
            ocad_pkg::OCAD_STANDARD: begin
            end
            ocad_pkg::OCAD_COLOUR_DOT: begin
                // Code is seven bits wide here; dots of palette 0 take the per-character colour
                char_code_o = {3'h0, code_i[6:0]};
                fg_pal_o    = (font_pal_i == `OCAD_PAL_TRANSPARENT) ? dot_pal : font_pal_i;
                bg_pal_o    = `OCAD_PAL_TRANSPARENT;
            end
            default: begin
            end
        endcase
        sec_blank_o      = attr1_i[`OCAD_A1_SEC];
        fg_transparent_o = (fg_pal_o == `OCAD_PAL_TRANSPARENT);
        fg_black_o       = (fg_pal_o == `OCAD_PAL_BLACK);
        bg_transparent_o = (bg_pal_o == `OCAD_PAL_TRANSPARENT);
        bg_black_o       = (bg_pal_o == `OCAD_PAL_BLACK);
    end

endmodule

// *** dv/ocad_char_attr_monitor.sv ***
`timescale 1ns/1ns
module ocad_char_attr_monitor (
    input wire logic       clk_i,                    // System clock
    input wire logic       arst_n_i,                 // Async reset, active low
    input wire logic       avs_read_i,               // Bus read
    input wire logic       avs_write_i,              // Bus write
    input wire logic       avs_waitrequest_o,        // Bus wait
    input wire logic       disp_req_i,               // Fetch request
    input wire logic       disp_valid_o,             // Fetch done
    input wire logic [9:0] char_code_o,              // Font code
    input wire logic [3:0] fg_pal_o,                 // Foreground palette
    input wire logic [3:0] bg_pal_o,                 // Background palette
    input wire logic       secondary_blank_output_o, // Secondary blank
    input wire logic       fg_transparent_o,         // Foreground clear
    input wire logic       fg_black_o,               // Foreground black
    input wire logic       bg_transparent_o,         // Background clear
    input wire logic       bg_black_o                // Background black
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // A fresh request waits exactly two edges, then one answer cycle
    property p_wait_lat; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o [*2] ##1 !avs_waitrequest_o; endproperty
    a_wait_lat: assert property (p_wait_lat) else $error("bus answer late or early");
    property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer held too long");
    property p_wait_cause; !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i, 2); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("bus answer without request");
    // Fetch pipeline is fixed at two edges, so the renderer can count on it
    property p_valid_lat; disp_req_i |-> ##2 disp_valid_o; endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("fetch result missing");
    property p_valid_cause; disp_valid_o |-> $past(disp_req_i, 2); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("fetch result without request");
    property p_hold; !disp_valid_o |-> $stable({char_code_o, fg_pal_o, bg_pal_o, secondary_blank_output_o}); endproperty
    a_hold: assert property (p_hold) else $error("fields moved between fetches");
    property p_fg_fix; disp_valid_o |-> fg_transparent_o == (fg_pal_o == 4'h0) && fg_black_o == (fg_pal_o == 4'h8); endproperty
    a_fg_fix: assert property (p_fg_fix) else $error("foreground fixed palette flag wrong");
    property p_bg_fix; disp_valid_o |-> bg_transparent_o == (bg_pal_o == 4'h0) && bg_black_o == (bg_pal_o == 4'h8); endproperty
    a_bg_fix: assert property (p_bg_fix) else $error("background fixed palette flag wrong");
endmodule

bind ocad_char_attr ocad_char_attr_monitor mon_u (.clk_i, .arst_n_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .disp_req_i, .disp_valid_o, .char_code_o, .fg_pal_o, .bg_pal_o, .secondary_blank_output_o, .fg_transparent_o,
    .fg_black_o, .bg_transparent_o, .bg_black_o);

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    logic clk_i = 1'b0, arst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, req = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [31:0] wd = 32'h0, q, rdata;
    logic [7:0] idx = 8'h0;
    logic [3:0] font = 4'h0, fg, bg;
    logic [9:0] code;
    logic wreq, vld, it, fl, ul, sb, ft, fb, bt, bb;
    int error_cnt = 0;
    int total_checks = 0;
    ocad_char_attr dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_byteenable_i(4'h1), .avs_writedata_i(wd), .avs_readdata_o(q), .avs_waitrequest_o(wreq),
        .disp_req_i(req), .disp_index_i(idx), .font_dot_pal_i(font), .disp_valid_o(vld), .char_code_o(code),
        .fg_pal_o(fg), .bg_pal_o(bg), .italic_o(it), .flash_o(fl), .underline_o(ul), .secondary_blank_output_o(sb),
        .fg_transparent_o(ft), .fg_black_o(fb), .bg_transparent_o(bt), .bg_black_o(bb));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One bus access; the request stands until waitrequest is seen low
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk_i);
        end while (wreq !== 1'b0);
        rdata = q;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Set the mode, fetch one character and compare every decoded field
    task automatic dec(input logic [2:0] c, input logic [7:0] i, input logic [3:0] f, input logic [9:0] ec,
                       input logic [3:0] efg, input logic [3:0] ebg, input logic [3:0] efl);
        bus(1'b1, 12'hc00, {5'h0, c});
        @(posedge clk_i);
        req <= 1'b1;
        idx <= i;
        font <= f;
        @(posedge clk_i);
        req <= 1'b0;
        @(posedge clk_i);
        #1;
        `CHK(vld, 1'b1)
        `CHK(code, ec)
        `CHK(fg, efg)
        `CHK(bg, ebg)
        `CHK({it, fl, ul, sb}, efl)
        `CHK({ft, fb, bt, bb}, {efg == 4'h0, efg == 4'h8, ebg == 4'h0, ebg == 4'h8})
        $display("decode test done, mode %h char %h", c, i);
    endtask
    initial forever #5 clk_i = ~clk_i;
    // Cuts a hang short well past the hundred or so cycles the tests need
    initial begin
        #100000;
        error_cnt++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        `CHK({wreq, vld, ft, bt}, 4'b1011)
        arst_n_i <= 1'b1;
        $display("reset test done");
        bus(1'b1, 12'h014, 8'ha5);
        bus(1'b1, 12'h414, 8'hb5);
        bus(1'b1, 12'h814, 8'hfe);
        bus(1'b1, 12'h018, 8'h3c);
        bus(1'b1, 12'h418, 8'h4a);
        bus(1'b1, 12'h818, 8'h00);
        bus(1'b0, 12'h014, 8'h00);
        `CHK(rdata, 32'h000000a5)
        bus(1'b0, 12'h414, 8'h00);
        `CHK(rdata, 32'h000000b5)
        bus(1'b0, 12'h814, 8'h00);
        `CHK(rdata, 32'h00000006)
        bus(1'b0, 12'hc08, 8'h00);
        `CHK(rdata, 32'h00000000)
        $display("map test done");
        // Caption banks, standard mode and colour-dot with replaced and kept dots
        dec(3'h0, 8'h05, 4'h0, 10'h3a5, 4'h2, 4'h2, 4'b1101);
        dec(3'h4, 8'h05, 4'h0, 10'h3a5, 4'ha, 4'h2, 4'b1101);
        dec(3'h0, 8'h06, 4'h0, 10'h03c, 4'h5, 4'h0, 4'b0010);
        dec(3'h1, 8'h05, 4'h0, 10'h3a5, 4'ha, 4'h9, 4'b0001);
        dec(3'h2, 8'h05, 4'h0, 10'h025, 4'h6, 4'h0, 4'b0001);
        dec(3'h2, 8'h05, 4'h8, 10'h025, 4'h8, 4'h0, 4'b0001);
        bus(1'b0, 12'hc00, 8'h00);
        `CHK(rdata, 32'h00000002)
        report_and_stop;
    end
endmodule
